// >>> pkg/dllsw_defs.vh
`ifndef DLLSW_DEFS_VH
`define DLLSW_DEFS_VH

// ----------------------------------------------------------------------
// command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define DLLSW_CMD_NOP 4'h7
`define DLLSW_CMD_MRS 4'h0
`define DLLSW_CMD_REF 4'h1
`define DLLSW_CMD_ZQC 4'h6

// ----------------------------------------------------------------------
// mode register selects and field positions
// ----------------------------------------------------------------------
`define DLLSW_BA_LATENCY_MR 3'h0
`define DLLSW_BA_DLL_CTRL_MR 3'h1
`define DLLSW_DLL_DISABLE_BIT 0
`define DLLSW_DLL_RESET_BIT 8
`define DLLSW_ZQ_LONG_BIT 10

// ----------------------------------------------------------------------
// default wait counts, in cycles of the controller clock
// ----------------------------------------------------------------------
`define DLLSW_MODE_SET_TO_CMD 16'h000c
`define DLLSW_MODE_SET_CYCLE 16'h0004
`define DLLSW_SR_EXIT_DELAY 16'h0100
`define DLLSW_CLK_HOLD_SRE 16'h0005
`define DLLSW_CLK_STABLE_SRX 16'h0005
`define DLLSW_DLL_LOCK 16'h0200
`define DLLSW_CAL_OPER 16'h0200

`endif

// >>> rtl/dllsw_wait_timer.v
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// down counter: load a count, done pulses high in the cycle the count stands at one, or at zero after a zero load
// ----------------------------------------------------------------------
module dllsw_wait_timer #(
  parameter W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] count,
  output wire busy,
  output wire done
);
  reg [W-1:0] cnt_q;
  reg run_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        run_q <= 1'b0;
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = run_q;
  assign done = run_q && (cnt_q <= {{(W-1){1'b0}}, 1'b1});
endmodule // dllsw_wait_timer

// >>> rtl/dllsw_ctrl.v
`timescale 1ns/100ps
// Summary of operation
// - frequency change to dll-off happens only while in self-refresh.
// - before dll-disable write, banks precharged, timings met, termination off.
// - after disable write wait mode-set delay, enter self-refresh, hold clock.
// - new clock stable for clock-stable interval before self-refresh exit.
// - dll-off path keeps clock enable high until mode-set delays pass.
// - dll-off path holds termination pin low if termination was enabled.
// - wait exit delay, rewrite mode registers, optional long calibration.
// - before self-refresh for dll-on, idle with termination off.
// - dll-on path keeps clock enable high until lock time after reset.
// - dll-on path holds termination pin low until lock time after reset.
// - after exit delay write dll-disable bit zero.
// - wait mode-set cycle delay, then write dll reset bit one.
// - wait mode-set cycle delay, update mode registers, optional calibration.
// - mode-set delay before next command, lock wait, calibration wait.
`include "dllsw_defs.vh"

module dllsw_ctrl #(
  parameter TW = 16,
  parameter [15:0] T_MOD = `DLLSW_MODE_SET_TO_CMD,
  parameter [15:0] T_MRD = `DLLSW_MODE_SET_CYCLE,
  parameter [15:0] T_XS = `DLLSW_SR_EXIT_DELAY,
  parameter [15:0] T_CKSRE = `DLLSW_CLK_HOLD_SRE,
  parameter [15:0] T_CKSRX = `DLLSW_CLK_STABLE_SRX,
  parameter [15:0] T_DLLK = `DLLSW_DLL_LOCK,
  parameter [15:0] T_ZQOPER = `DLLSW_CAL_OPER
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire to_dll_off,
  input wire idle_ok,
  input wire term_enabled,
  input wire do_cal,
  input wire [15:0] new_mr0,
  input wire [15:0] new_mr1,
  input wire freq_stable,
  output reg freq_change_ok,
  output reg busy,
  output reg done,
  output reg cke,
  output reg cs_n,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [2:0] ba,
  output reg [15:0] addr,
  output reg termination_control_pin,
  output reg dll_locked_ok
);
  // --------------------------------------------------------------------
  // reset release and input synchronisers
  // --------------------------------------------------------------------
  // reset takes hold at once but is released on the clock, so no flop sees
  // a release edge that lands close to its own clock edge
  reg rst_s1_q, rst_s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rs_n = rst_s2_q;

  // the stable flag comes from the clock source, outside this domain
  reg fs1_q, fs2_q;
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      fs1_q <= 1'b0;
      fs2_q <= 1'b0;
    end else begin
      fs1_q <= freq_stable;
      fs2_q <= fs1_q;
    end
  end

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [11:0] S_IDLE = 12'h001;
  localparam [11:0] S_DIS = 12'h002;
  localparam [11:0] S_SRE = 12'h004;
  localparam [11:0] S_HOLD = 12'h008;
  localparam [11:0] S_FREQ = 12'h010;
  localparam [11:0] S_SRX = 12'h020;
  localparam [11:0] S_XS = 12'h040;
  localparam [11:0] S_EN = 12'h080;
  localparam [11:0] S_RST = 12'h100;
  localparam [11:0] S_MR = 12'h200;
  localparam [11:0] S_CAL = 12'h400;
  localparam [11:0] S_FIN = 12'h800;

  reg [11:0] st_q, st_d;
  reg off_q, term_q, cal_q, mr1_pend_q;
  reg [15:0] mr0_q, mr1_q;
  reg [15:0] lock_q;
  reg [TW-1:0] wcount;
  reg wload;
  wire tbusy, tdone;

  // one shared timer is enough: apart from the lock wait on lock_q, the sequence never runs two waits at once;
  // a count of n puts n clocks between the two commands on the pins, n+1 from the dll-disable write to self-refresh entry
  dllsw_wait_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rst_n(rs_n),
    .load(wload),
    .count(wcount),
    .busy(tbusy),
    .done(tdone)
  );

  // issue helpers
  reg [3:0] cmd_d;
  reg [2:0] ba_d;
  reg [15:0] addr_d;
  reg cke_d, term_d;

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always @* begin
    st_d = st_q;
    wload = 1'b0;
    wcount = {TW{1'b0}};
    cmd_d = `DLLSW_CMD_NOP;
    ba_d = 3'h0;
    addr_d = 16'h0000;
    cke_d = cke;
    // termination held low in every state, idle included
    term_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        cke_d = 1'b1;
        if (start && idle_ok) begin
          if (to_dll_off) begin
            cmd_d = `DLLSW_CMD_MRS;
            ba_d = `DLLSW_BA_DLL_CTRL_MR;
            addr_d = mr1_q | (16'h0001 << `DLLSW_DLL_DISABLE_BIT);
            wload = 1'b1;
            wcount = T_MOD[TW-1:0];
            st_d = S_DIS;
          end else begin
            st_d = S_SRE;
          end
        end
      end
      S_DIS: if (tdone) st_d = S_SRE;
      S_SRE: begin
        cmd_d = `DLLSW_CMD_REF;
        cke_d = 1'b0;
        wload = 1'b1;
        wcount = T_CKSRE[TW-1:0];
        st_d = S_HOLD;
      end
      S_HOLD: if (tdone) st_d = S_FREQ;
      S_FREQ: begin
        // clock may change here and in S_SRX, both inside self-refresh
        if (fs2_q && !tbusy) begin
          wload = 1'b1;
          wcount = T_CKSRX[TW-1:0];
          st_d = S_SRX;
        end
      end
      S_SRX: begin
        // a clock that drops out of stable restarts the stable wait
        if (!fs2_q) begin
          st_d = S_FREQ;
        end else if (tdone) begin
          cke_d = 1'b1;
          wload = 1'b1;
          wcount = T_XS[TW-1:0];
          st_d = S_XS;
        end
      end
      S_XS: begin
        if (tdone) begin
          wload = 1'b1;
          wcount = T_MRD[TW-1:0];
          cmd_d = `DLLSW_CMD_MRS;
          if (off_q) begin
            ba_d = `DLLSW_BA_LATENCY_MR;
            addr_d = mr0_q & ~(16'h0001 << `DLLSW_DLL_RESET_BIT);
            st_d = S_MR;
          end else begin
            ba_d = `DLLSW_BA_DLL_CTRL_MR;
            addr_d = mr1_q & ~(16'h0001 << `DLLSW_DLL_DISABLE_BIT);
            st_d = S_EN;
          end
        end
      end
      S_EN: begin
        if (tdone) begin
          cmd_d = `DLLSW_CMD_MRS;
          ba_d = `DLLSW_BA_LATENCY_MR;
          addr_d = mr0_q | (16'h0001 << `DLLSW_DLL_RESET_BIT);
          wload = 1'b1;
          wcount = T_MRD[TW-1:0];
          st_d = S_RST;
        end
      end
      S_RST: begin
        if (tdone) begin
          cmd_d = `DLLSW_CMD_MRS;
          ba_d = `DLLSW_BA_LATENCY_MR;
          addr_d = mr0_q & ~(16'h0001 << `DLLSW_DLL_RESET_BIT);
          wload = 1'b1;
          wcount = T_MOD[TW-1:0];
          st_d = S_MR;
        end
      end
      S_MR: begin
        if (tdone) begin
          if (mr1_pend_q) begin
            // closing write of the dll control register keeps the new disable state
            cmd_d = `DLLSW_CMD_MRS;
            ba_d = `DLLSW_BA_DLL_CTRL_MR;
            addr_d = off_q ? (mr1_q | 16'h0001) : (mr1_q & 16'hfffe);
            wload = 1'b1;
            wcount = T_MOD[TW-1:0];
          end else if (cal_q) begin
            cmd_d = `DLLSW_CMD_ZQC;
            addr_d = 16'h0001 << `DLLSW_ZQ_LONG_BIT;
            wload = 1'b1;
            wcount = T_ZQOPER[TW-1:0];
            st_d = S_CAL;
          end else begin
            st_d = S_FIN;
          end
        end
      end
      S_CAL: if (tdone) st_d = S_FIN;
      S_FIN: begin
        // sequence ends once the lock wait is over, at once on the dll-off path; cke stays high and termination low
        if (off_q || lock_q == 16'h0000) begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (st_q == S_IDLE && st_d == S_IDLE) term_d = 1'b0;
  end

  // --------------------------------------------------------------------
  // registered outputs and context
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      st_q <= S_IDLE;
      off_q <= 1'b0;
      term_q <= 1'b0;
      cal_q <= 1'b0;
      mr1_pend_q <= 1'b0;
      mr0_q <= 16'h0000;
      mr1_q <= 16'h0000;
      lock_q <= 16'h0000;
      cke <= 1'b0;
      {cs_n, ras_n, cas_n, we_n} <= `DLLSW_CMD_NOP;
      ba <= 3'h0;
      addr <= 16'h0000;
      termination_control_pin <= 1'b0;
      freq_change_ok <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      dll_locked_ok <= 1'b1;
    end else begin
      st_q <= st_d;
      cke <= cke_d;
      {cs_n, ras_n, cas_n, we_n} <= cmd_d;
      ba <= ba_d;
      addr <= addr_d;
      termination_control_pin <= term_d;
      freq_change_ok <= (st_d == S_FREQ) || (st_d == S_SRX);
      busy <= (st_d != S_IDLE);
      done <= (st_q == S_FIN) && (st_d == S_IDLE);
      // the pin is held low whether or not termination was enabled, always legal
      if (st_q == S_IDLE && start && idle_ok) begin
        off_q <= to_dll_off;
        term_q <= term_enabled;
        cal_q <= do_cal;
        mr0_q <= new_mr0;
        mr1_q <= new_mr1;
        mr1_pend_q <= 1'b1;
        dll_locked_ok <= 1'b0;
      end
      if (st_q == S_MR && tdone && mr1_pend_q) mr1_pend_q <= 1'b0;
      // lock time runs from the dll reset write, alongside the remaining
      // mode writes and the calibration
      if (st_q == S_EN && tdone) begin
        lock_q <= T_DLLK;
      end else if (lock_q != 16'h0000) begin
        lock_q <= lock_q - 16'h0001;
      end
      // in dll-off mode there is no lock, so locked commands stay withheld
      if (st_q == S_FIN && st_d == S_IDLE) dll_locked_ok <= !off_q;
    end
  end
endmodule // dllsw_ctrl

// >>> sim/dllsw_chk_assertions.sv
`timescale 1ns/100ps
`include "dllsw_defs.vh"
module dllsw_chk #(
  parameter [15:0] T_MOD = 16'h0006,
  parameter [15:0] T_CKSRX = 16'h0003
) (
  input wire clk,
  input wire rst_n,
  input wire to_dll_off,
  input wire idle_ok,
  input wire freq_stable,
  input wire freq_change_ok,
  input wire busy,
  input wire done,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] ba,
  input wire [15:0] addr,
  input wire termination_control_pin
);
  localparam int D_MOD = T_MOD + 1;
  localparam int D_SRX = T_CKSRX;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire mrs = cmd == `DLLSW_CMD_MRS;
  wire mrs_off = mrs && ba == 3'h1 && addr[0];
  reg cke_p_q;
  reg out_q;
  reg [2:0] idx_q;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // out_q: past self-refresh exit; idx_q counts mode writes since then
  // ----
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_p_q <= 1'b0;
      out_q <= 1'b0;
      idx_q <= 3'h0;
    end else begin
      cke_p_q <= cke;
      out_q <= busy && (out_q || (cke && !cke_p_q));
      idx_q <= !out_q ? 3'h0 : idx_q + {2'h0, mrs};
    end
  end
  a_term_low: assert property (!termination_control_pin)
    else $error("termination pin high");
  a_sr_cke_low: assert property (freq_change_ok |-> !cke)
    else $error("cke high while frequency may change");
  a_disable_mod: assert property (cmd == `DLLSW_CMD_REF && to_dll_off |-> $past(mrs_off, D_MOD))
    else $error("self-refresh entry not one mode-set delay after disable");
  a_srx_stable: assert property ($rose(cke) && busy |-> freq_stable && $past(freq_stable, D_SRX))
    else $error("exit before clock stable");
  a_cke_hold: assert property (out_q |-> cke)
    else $error("cke dropped after exit");
  // repetition counts follow T_XS=8 and T_MRD=4 set by the bench
  // a mode-set gap of four clocks leaves three idle cycles between the writes
  a_exit_wait: assert property ($rose(cke) && busy |-> (cmd == `DLLSW_CMD_NOP)[*8])
    else $error("command inside exit delay");
  a_mrs_gap: assert property (mrs |=> (cmd == `DLLSW_CMD_NOP)[*3])
    else $error("command inside mode-set gap");
  a_on_order: assert property (mrs && out_q && !to_dll_off && idx_q < 3'h2 |->
    (idx_q == 3'h0 ? (ba == 3'h1 && !addr[0]) : (ba == 3'h0 && addr[8])))
    else $error("dll enable writes out of order");
  a_refuse_idle: assert property (!busy && !idle_ok |=> !busy)
    else $error("start taken without idle");
  c_off: cover property (mrs_off && busy);
  c_dll_reset: cover property (mrs && ba == 3'h0 && addr[8]);
  c_cal: cover property (cmd == `DLLSW_CMD_ZQC);
  c_done_off: cover property (done && to_dll_off);
endmodule // dllsw_chk

bind dllsw_ctrl dllsw_chk #(.T_MOD(T_MOD), .T_CKSRX(T_CKSRX)) chk (.clk, .rst_n, .to_dll_off,
  .idle_ok, .freq_stable, .freq_change_ok, .busy, .done, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .ba, .addr, .termination_control_pin);

// >>> sim/dllsw_dram_model.sv
`timescale 1ns/100ps
`include "dllsw_defs.vh"
module dllsw_dram_model (
  input wire clk,
  input wire cke,
  input wire [3:0] cmd,
  input wire [2:0] ba,
  input wire [15:0] addr,
  output reg dll_off,
  output reg [15:0] lat_mr
);
  initial dll_off = 1'b0;
  initial lat_mr = 16'h0000;
  // commands count only while the device sees clock enable
  always @(posedge clk) begin
    if (cke && cmd == `DLLSW_CMD_MRS && ba == `DLLSW_BA_DLL_CTRL_MR) begin
      dll_off <= addr[`DLLSW_DLL_DISABLE_BIT];
    end
    if (cke && cmd == `DLLSW_CMD_MRS && ba == `DLLSW_BA_LATENCY_MR) begin
      lat_mr <= addr;
    end
  end
endmodule // dllsw_dram_model

// >>> sim/dllsw_ctrl_tb.sv
`timescale 1ns/100ps
`include "dllsw_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t mismatch %h %h", $time, (a), (b)); end end
module dllsw_ctrl_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg start = 1'b0;
  reg to_dll_off = 1'b0;
  reg idle_ok = 1'b0;
  reg term_enabled = 1'b0;
  reg do_cal = 1'b0;
  reg [15:0] new_mr0 = 16'h0a30;
  reg [15:0] new_mr1 = 16'h0046;
  reg freq_stable = 1'b0;
  reg seen_fc;
  wire freq_change_ok, busy, done, cke, cs_n, ras_n, cas_n, we_n;
  wire termination_control_pin, dll_locked_ok, dll_off;
  wire [2:0] ba;
  wire [15:0] addr;
  wire [15:0] lat_mr;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  integer num_errors = 0;
  integer check_count = 0;
  integer n_mrs, n_ref, n_zq, n_rst, n_cyc, i;
  always #4 clk = ~clk;
  // clock hold and clock-stable waits run at their defaults
  dllsw_ctrl #(.T_MOD(16'h0006), .T_MRD(16'h0004), .T_XS(16'h0008), .T_DLLK(16'h0028),
    .T_ZQOPER(16'h0005)) uut (.clk, .rst_n, .start,
    .to_dll_off, .idle_ok, .term_enabled, .do_cal, .new_mr0, .new_mr1, .freq_stable,
    .freq_change_ok, .busy, .done, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .termination_control_pin, .dll_locked_ok);
  dllsw_dram_model dram (.clk, .cke, .cmd, .ba, .addr, .dll_off, .lat_mr);
  // ----
  // command monitor
  // ----
  always @(posedge clk) begin
    // cycles since the last dll reset write
    if (cmd == `DLLSW_CMD_MRS && ba == 3'h0 && addr[8]) n_cyc <= 0;
    else n_cyc <= n_cyc + 1;
    if (cmd == `DLLSW_CMD_MRS) n_mrs <= n_mrs + 1;
    if (cmd == `DLLSW_CMD_REF) n_ref <= n_ref + 1;
    if (cmd == `DLLSW_CMD_ZQC && addr[10]) n_zq <= n_zq + 1;
    if (cmd == `DLLSW_CMD_MRS && ba == 3'h0 && addr[8]) n_rst <= n_rst + 1;
    if (freq_change_ok === 1'b1) seen_fc <= 1'b1;
  end
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // a second start mid-run must be ignored; the counts would show a restart
  task run_switch(input reg off, input reg cal);
    integer k;
    integer fs_k;
    begin
      k = 0;
      fs_k = 0;
      to_dll_off = off;
      do_cal = cal;
      term_enabled = cal;
      idle_ok = 1'b1;
      freq_stable = 1'b0;
      // fresh mode values each run, so a missed write shows up
      new_mr0 = new_mr0 + 16'h0010;
      new_mr1 = 16'h0046 | {15'h0000, !off};
      n_mrs = 0; n_ref = 0; n_zq = 0; n_rst = 0; n_cyc = 0; seen_fc = 1'b0;
      start = 1'b1;
      // the done pulse of the run before may still stand on entry
      while ((k == 0 || done !== 1'b1) && k < 3000) begin
        @(negedge clk);
        k = k + 1;
        start = (k == 10);
        if (freq_change_ok === 1'b1) fs_k = fs_k + 1;
        if (fs_k == 4) freq_stable = 1'b1;
      end
      if (k == 3000) begin
        num_errors++;
        tally_and_finish;
      end
      `CHK(dll_off, off)
      `CHK(n_mrs, off ? 3 : 4)
      `CHK(n_ref, 1)
      `CHK(seen_fc, 1'b1)
      `CHK(n_zq, {31'h0, cal})
      `CHK(n_rst, {31'h0, !off})
      `CHK(lat_mr, new_mr0)
      `CHK(dll_locked_ok, !off)
      `CHK(off || n_cyc >= 40, 1'b1)
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(cke, 1'b1)
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(busy, 1'b0)
    for (i = 0; i < 4; i = i + 1) run_switch(!i[0], i[0] ^ i[1]);
    tally_and_finish;
  end
endmodule // dllsw_ctrl_tb
